// >>> design/dicr_defs.vh
// Register map, field positions, reset values and serial frame constants.
`ifndef DICR_DEFS_VH
`define DICR_DEFS_VH

`define DICR_ADDR_W 7
`define DICR_ADDR_IRQ_EN 7'h03
`define DICR_ADDR_IRQ_ST 7'h04
`define DICR_ADDR_FSC_LO 7'h06
`define DICR_ADDR_FSC_HI 7'h07
`define DICR_ADDR_MODE 7'h08
`define DICR_ADDR_DCLK_PH 7'h0C
`define DICR_ADDR_SYNC_PH 7'h0D
`define DICR_ADDR_CFG 7'h10

`define DICR_IRQ_EN_RST 6'h00
`define DICR_IRQ_ST_RST 6'h00
`define DICR_FSC_LO_RST 8'h00
`define DICR_FSC_HI_RST 2'h2
`define DICR_MODE_RST 2'h0
`define DICR_CFG_RST 8'h42

`define DICR_MODE_BASEBAND 2'h0
`define DICR_MODE_RTZ 2'h1
`define DICR_MODE_MIX 2'h2

`define DICR_BIT_SLEEP 7
`define DICR_BIT_CLK_EARLY 2
`define DICR_BIT_CLK_LATE 0
`define DICR_BIT_SYNC_PH90 5
`define DICR_BIT_SYNC_PH0 4
`define DICR_BIT_SYNC_CLR 7
`define DICR_BIT_SYNC_LOOP 6
`define DICR_BIT_SYNC_ROLE 5
`define DICR_BIT_SYNC_EN 4
`define DICR_BIT_RCV_CLR 2
`define DICR_BIT_RCV_LOOP 1
`define DICR_BIT_RCV_EN 0

`define DICR_CMD_BITS 5'h08
`define DICR_FRAME_BITS 5'h10

`endif

// >>> design/dicr_regs.v
// Interrupt, full-scale current, switching mode and lock controller registers.
`timescale 1ns/1ps
`include "dicr_defs.vh"

module dicr_regs #(
   parameter CODE_W = 10
) (
   // Clock and reset
   input wire clk_sys,
   input wire resetn,
   // Serial configuration port
   input wire spi_sclk,
   input wire spi_csn,
   input wire spi_sdi,
   output wire spi_sdo,
   output wire spi_sdo_oe,
   // Lock levels from the three controllers
   input wire sync_lock,
   input wire phase_ctrl_lock,
   input wire receiver_lock,
   // Phase comparator levels
   input wire clock_early_phase0_status,
   input wire clock_late_phase0_status,
   input wire sync_in_phase90_status,
   input wire sync_in_phase0_status,
   // Converter controls
   output wire [CODE_W-1:0] full_scale_code,
   output wire dac_sleep,
   output wire [1:0] switch_mode_field,
   // Lock controller controls
   output wire sync_ctrl_enable,
   output wire sync_role_select,
   output wire sync_auto_relock,
   output wire receiver_ctrl_enable,
   output wire receiver_auto_relock,
   output wire sync_flag_clear,
   output wire receiver_flag_clear,
   output wire sync_restart,
   output wire receiver_restart,
   // Interrupt request level
   output wire irq_request
);
   wire [6:0] reg_addr;
   wire [7:0] reg_wdata;
   wire reg_wr;
   reg [7:0] reg_rdata;

   reg [5:0] irq_enable_reg;
   reg [5:0] irq_status_reg;
   reg [5:0] irq_status_next;
   reg [7:0] fsc_lo_reg;
   reg [1:0] fsc_hi_reg;
   reg sleep_reg;
   reg [1:0] mode_reg;
   reg [3:0] phase_reg;
   reg sync_arm_reg;
   reg sync_loop_reg;
   reg sync_role_reg;
   reg sync_en_reg;
   reg rcv_arm_reg;
   reg rcv_loop_reg;
   reg rcv_en_reg;
   reg [2:0] lock_prev_reg;
   reg sync_clr_reg;
   reg rcv_clr_reg;
   reg sync_restart_reg;
   reg rcv_restart_reg;
   reg sync_loop_flag_reg;
   reg rcv_loop_flag_reg;
   reg irq_reg;

   wire [2:0] lock_now;
   wire [5:0] event_vec;
   wire [5:0] flag_clr;
   wire wr_en;
   wire wr_fsc_lo;
   wire wr_fsc_hi;
   wire wr_mode;
   wire wr_cfg;
   wire sync_clr_hit;
   wire rcv_clr_hit;
   wire sync_lost_ev;
   wire rcv_lost_ev;
   wire sync_relock_hit;
   wire rcv_relock_hit;
   wire irq_any;

   // The serial slave turns frames into one-cycle write strobes and a read address.
   dicr_spi_slave u_spi (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .spi_sclk(spi_sclk),
      .spi_csn(spi_csn),
      .spi_sdi(spi_sdi),
      .spi_sdo(spi_sdo),
      .spi_sdo_oe(spi_sdo_oe),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rdata(reg_rdata)
   );

   // Writes to read-only or unmapped addresses decode to nothing and are ignored.
   assign wr_en = reg_wr && reg_addr == `DICR_ADDR_IRQ_EN;
   assign wr_fsc_lo = reg_wr && reg_addr == `DICR_ADDR_FSC_LO;
   assign wr_fsc_hi = reg_wr && reg_addr == `DICR_ADDR_FSC_HI;
   assign wr_mode = reg_wr && reg_addr == `DICR_ADDR_MODE;
   assign wr_cfg = reg_wr && reg_addr == `DICR_ADDR_CFG;

   // Index 2 is sync, 1 is the clock-phase controller, 0 is the receiver.
   assign lock_now = {sync_lock, phase_ctrl_lock, receiver_lock};

   genvar k;
   generate
      for (k = 0; k < 3; k = k + 1) begin : g_event
         // Even bits are locked events, odd bits are lost events.
         assign event_vec[2*k] = lock_now[k] & ~lock_prev_reg[k];
         assign event_vec[2*k+1] = ~lock_now[k] & lock_prev_reg[k];
      end
   endgenerate

   // A clear fires only on a zero written over a stored one, so a single
   // zero write never disturbs the flags.
   // sync flag clear
   assign sync_clr_hit = wr_cfg & sync_arm_reg & ~reg_wdata[`DICR_BIT_SYNC_CLR];
   assign rcv_clr_hit = wr_cfg & rcv_arm_reg & ~reg_wdata[`DICR_BIT_RCV_CLR];
   assign flag_clr = {sync_clr_hit, sync_clr_hit, 2'b00, rcv_clr_hit, rcv_clr_hit};

   // A lost event is a falling lock level seen against the previous sample.
   assign sync_lost_ev = event_vec[5];
   assign rcv_lost_ev = event_vec[1];
   assign sync_relock_hit = sync_lost_ev & sync_loop_reg & sync_role_reg & sync_en_reg;
   assign rcv_relock_hit = rcv_lost_ev & rcv_loop_reg & rcv_en_reg;

   // The relock flags keep the request up even when every status enable is off,
   // because an automatic restart must always reach the host.
   assign irq_any = (|irq_status_next) | sync_loop_flag_reg | rcv_loop_flag_reg
      | sync_relock_hit | rcv_relock_hit;

   // An event that meets a clear in the same cycle keeps its bit set, so no
   // lock change is lost while software services the previous one.
   integer i;
   always @* begin
      irq_status_next = irq_status_reg;
      for (i = 0; i < 6; i = i + 1) begin
         if (event_vec[i] && irq_enable_reg[i]) begin
            irq_status_next[i] = 1'b1;
         end else if (wr_en && !reg_wdata[i]) begin
            irq_status_next[i] = 1'b0;
         end else if (flag_clr[i]) begin
            irq_status_next[i] = 1'b0;
         end else if ((i % 2) == 0 && event_vec[i | 1]) begin
            irq_status_next[i] = 1'b0;
         end
      end
   end

   // Status and enable storage.
   // Enable bits 7:6 have no event behind them and are dropped on write.
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         irq_enable_reg <= `DICR_IRQ_EN_RST;
         irq_status_reg <= `DICR_IRQ_ST_RST;
         // Controllers count as unlocked at reset; a lock held then fires a locked event, but the enables are still zero so no bit is set.
         lock_prev_reg <= 3'h0;
      end else begin
         lock_prev_reg <= lock_now;
         irq_status_reg <= irq_status_next;
         if (wr_en) begin
            irq_enable_reg <= reg_wdata[5:0];
         end
      end
   end

   // Converter settings.
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         fsc_lo_reg <= `DICR_FSC_LO_RST;
         fsc_hi_reg <= `DICR_FSC_HI_RST;
         sleep_reg <= 1'b0;
         mode_reg <= `DICR_MODE_RST;
         phase_reg <= 4'h0;
      end else begin
         if (wr_fsc_lo) begin
            fsc_lo_reg <= reg_wdata;
         end
         if (wr_fsc_hi) begin
            fsc_hi_reg <= reg_wdata[1:0];
            sleep_reg <= reg_wdata[`DICR_BIT_SLEEP];
         end
         // Code 3 is stored and read back as written; it selects no defined mode.
         // switching mode field
         if (wr_mode) begin
            mode_reg <= reg_wdata[1:0];
         end
         // Comparator levels are sampled once per clock so that a readback sees
         // one settled value rather than a level changing under the shifter.
         phase_reg <= {sync_in_phase90_status, sync_in_phase0_status,
            clock_early_phase0_status, clock_late_phase0_status};
      end
   end

   // Lock controller configuration and its pulses.
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sync_arm_reg <= 1'b0;
         sync_loop_reg <= 1'b1;
         sync_role_reg <= 1'b0;
         sync_en_reg <= 1'b0;
         rcv_arm_reg <= 1'b0;
         rcv_loop_reg <= 1'b1;
         rcv_en_reg <= 1'b0;
         sync_clr_reg <= 1'b0;
         rcv_clr_reg <= 1'b0;
         sync_restart_reg <= 1'b0;
         rcv_restart_reg <= 1'b0;
         sync_loop_flag_reg <= 1'b0;
         rcv_loop_flag_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         if (wr_cfg) begin
            // Arm bits hold the last written clear bits for the one-then-zero sequence.
            sync_arm_reg <= reg_wdata[`DICR_BIT_SYNC_CLR];
            sync_loop_reg <= reg_wdata[`DICR_BIT_SYNC_LOOP];
            sync_role_reg <= reg_wdata[`DICR_BIT_SYNC_ROLE];
            sync_en_reg <= reg_wdata[`DICR_BIT_SYNC_EN];
            rcv_arm_reg <= reg_wdata[`DICR_BIT_RCV_CLR];
            rcv_loop_reg <= reg_wdata[`DICR_BIT_RCV_LOOP];
            rcv_en_reg <= reg_wdata[`DICR_BIT_RCV_EN];
         end
         sync_clr_reg <= sync_clr_hit;
         rcv_clr_reg <= rcv_clr_hit;
         sync_restart_reg <= sync_relock_hit;
         rcv_restart_reg <= rcv_relock_hit;
         // A loss in the same cycle as a clear keeps its flag.
         if (sync_relock_hit) begin
            sync_loop_flag_reg <= 1'b1;
         end else if (sync_clr_hit) begin
            sync_loop_flag_reg <= 1'b0;
         end
         if (rcv_relock_hit) begin
            rcv_loop_flag_reg <= 1'b1;
         end else if (rcv_clr_hit) begin
            rcv_loop_flag_reg <= 1'b0;
         end
         irq_reg <= irq_any;
      end
   end

   // Read multiplexer; write-only bits and unmapped addresses read zero.
   always @* begin
      reg_rdata = 8'h00;
      case (reg_addr)
         `DICR_ADDR_IRQ_ST: begin
            reg_rdata = {2'b00, irq_status_reg};
         end
         `DICR_ADDR_FSC_LO: begin
            reg_rdata = fsc_lo_reg;
         end
         `DICR_ADDR_FSC_HI: begin
            reg_rdata = {sleep_reg, 5'h00, fsc_hi_reg};
         end
         `DICR_ADDR_MODE: begin
            reg_rdata = {6'h00, mode_reg};
         end
         `DICR_ADDR_DCLK_PH: begin
            reg_rdata[`DICR_BIT_CLK_EARLY] = phase_reg[1];
            reg_rdata[`DICR_BIT_CLK_LATE] = phase_reg[0];
         end
         `DICR_ADDR_SYNC_PH: begin
            reg_rdata[`DICR_BIT_SYNC_PH90] = phase_reg[3];
            reg_rdata[`DICR_BIT_SYNC_PH0] = phase_reg[2];
         end
         `DICR_ADDR_CFG: begin
            // Flag-clear bits are write-only and read back as zero.
            reg_rdata = {1'b0, sync_loop_reg, sync_role_reg, sync_en_reg,
               2'b00, rcv_loop_reg, rcv_en_reg};
         end
         default: begin
            reg_rdata = 8'h00;
         end
      endcase
   end

   // The full-scale code is ten bits wide; CODE_W must stay at its default.
   assign full_scale_code = {fsc_hi_reg, fsc_lo_reg};
   assign dac_sleep = sleep_reg;
   assign switch_mode_field = mode_reg;
   assign sync_ctrl_enable = sync_en_reg;
   assign sync_role_select = sync_role_reg;
   assign sync_auto_relock = sync_loop_reg;
   assign receiver_ctrl_enable = rcv_en_reg;
   assign receiver_auto_relock = rcv_loop_reg;
   assign sync_flag_clear = sync_clr_reg;
   assign receiver_flag_clear = rcv_clr_reg;
   assign sync_restart = sync_restart_reg;
   assign receiver_restart = rcv_restart_reg;
   assign irq_request = irq_reg;
endmodule

// >>> design/dicr_spi_slave.v
// Serial configuration port slave: 16-bit frames, read flag, address, data.
`timescale 1ns/1ps

module dicr_spi_slave (
   // Clock and reset
   input wire clk_sys,
   input wire resetn,
   // Serial pins
   input wire spi_sclk,
   input wire spi_csn,
   input wire spi_sdi,
   output wire spi_sdo,
   output wire spi_sdo_oe,
   // Register side
   output wire [6:0] reg_addr,
   output wire [7:0] reg_wdata,
   output wire reg_wr,
   input wire [7:0] reg_rdata
);
   reg sclk_reg;
   reg [4:0] cnt_reg;
   reg [15:0] shin_reg;
   reg [7:0] shout_reg;
   reg [6:0] addr_reg;
   reg [7:0] wdata_reg;
   reg rd_reg;
   reg load_reg;
   reg wr_reg;
   reg sdo_reg;
   reg oe_reg;
   wire rise;
   wire fall;

   assign rise = spi_sclk & ~sclk_reg & ~spi_csn;
   assign fall = ~spi_sclk & sclk_reg & ~spi_csn;
   assign reg_addr = addr_reg;
   assign reg_wdata = wdata_reg;
   assign reg_wr = wr_reg;
   assign spi_sdo = sdo_reg;
   assign spi_sdo_oe = oe_reg;

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sclk_reg <= 1'b0;
         cnt_reg <= 5'h00;
         shin_reg <= 16'h0000;
         shout_reg <= 8'h00;
         addr_reg <= 7'h00;
         wdata_reg <= 8'h00;
         rd_reg <= 1'b0;
         load_reg <= 1'b0;
         wr_reg <= 1'b0;
         sdo_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else begin
         sclk_reg <= spi_sclk;
         load_reg <= 1'b0;
         wr_reg <= 1'b0;
         if (spi_csn) begin
            cnt_reg <= 5'h00;
            rd_reg <= 1'b0;
            oe_reg <= 1'b0;
         end else begin
            if (rise && cnt_reg != `DICR_FRAME_BITS) begin
               shin_reg <= {shin_reg[14:0], spi_sdi};
               cnt_reg <= cnt_reg + 5'h01;
               if (cnt_reg == `DICR_CMD_BITS - 5'h01) begin
                  addr_reg <= {shin_reg[5:0], spi_sdi};
                  rd_reg <= shin_reg[6];
                  load_reg <= shin_reg[6];
               end
               if (cnt_reg == `DICR_FRAME_BITS - 5'h01 && !rd_reg) begin
                  wdata_reg <= {shin_reg[6:0], spi_sdi};
                  wr_reg <= 1'b1;
               end
            end
            if (load_reg) begin
               shout_reg <= reg_rdata;
               oe_reg <= 1'b1;
            end else if (fall && rd_reg) begin
               sdo_reg <= shout_reg[7];
               shout_reg <= {shout_reg[6:0], 1'b0};
            end
         end
      end
   end
endmodule

// >>> verification/dicr_regs_checker.sv
// Concurrent checks on the ports of the interrupt and control register block.
`timescale 1ns/1ps

module dicr_regs_checker #(
   parameter CODE_W = 10
) (
   // Clock, reset and serial pins
   input logic clk_sys, resetn, spi_sclk, spi_csn, spi_sdi, spi_sdo, spi_sdo_oe,
   // Lock and comparator levels
   input logic sync_lock, phase_ctrl_lock, receiver_lock,
   input logic clock_early_phase0_status, clock_late_phase0_status,
   input logic sync_in_phase90_status, sync_in_phase0_status,
   // Converter and controller controls
   input logic [CODE_W-1:0] full_scale_code,
   input logic dac_sleep,
   input logic [1:0] switch_mode_field,
   input logic sync_ctrl_enable, sync_role_select, sync_auto_relock, receiver_ctrl_enable,
   input logic receiver_auto_relock, sync_flag_clear, receiver_flag_clear, sync_restart,
   input logic receiver_restart, irq_request
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   sequence s_sync_drop;
      $fell(sync_lock) && sync_ctrl_enable && sync_role_select && sync_auto_relock;
   endsequence
   sequence s_rcv_drop;
      $fell(receiver_lock) && receiver_ctrl_enable && receiver_auto_relock;
   endsequence
   sequence s_quiet;
      spi_csn [*3];
   endsequence

   reset_values_a: assert property ($rose(resetn) |-> full_scale_code == 10'h200
      && {dac_sleep, switch_mode_field, sync_ctrl_enable, receiver_ctrl_enable} == 5'h00
      && sync_auto_relock && receiver_auto_relock) else $error("reset values wrong");
   sync_relock_a: assert property (s_sync_drop |-> ##[1:3] sync_restart ##[0:2] irq_request)
      else $error("sync relock missing");
   rcv_relock_a: assert property (s_rcv_drop |-> ##[1:3] receiver_restart ##[0:2] irq_request)
      else $error("receiver relock missing");
   sync_cause_a: assert property (sync_restart |-> sync_ctrl_enable && sync_role_select
      && sync_auto_relock && !sync_lock) else $error("sync restart without cause");
   rcv_cause_a: assert property (receiver_restart |-> receiver_ctrl_enable
      && receiver_auto_relock && !receiver_lock) else $error("receiver restart without cause");
   sync_clear_a: assert property (sync_flag_clear |-> !spi_csn ##1 !sync_flag_clear)
      else $error("sync flag clear not a write pulse");
   rcv_clear_a: assert property (receiver_flag_clear |-> !spi_csn ##1 !receiver_flag_clear)
      else $error("receiver flag clear not a write pulse");
   quiet_outputs_a: assert property (s_quiet |-> $stable({full_scale_code, dac_sleep,
      switch_mode_field, sync_ctrl_enable, sync_role_select, receiver_ctrl_enable}))
      else $error("control output changed outside a frame");
   sdo_release_a: assert property (s_quiet |-> !spi_sdo_oe)
      else $error("serial output driven while deselected");
endmodule

bind dicr_regs dicr_regs_checker #(.CODE_W(CODE_W)) i_checker (
   .clk_sys(clk_sys), .resetn(resetn), .spi_sclk(spi_sclk), .spi_csn(spi_csn),
   .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .sync_lock(sync_lock),
   .phase_ctrl_lock(phase_ctrl_lock), .receiver_lock(receiver_lock),
   .clock_early_phase0_status(clock_early_phase0_status),
   .clock_late_phase0_status(clock_late_phase0_status),
   .sync_in_phase90_status(sync_in_phase90_status),
   .sync_in_phase0_status(sync_in_phase0_status), .full_scale_code(full_scale_code),
   .dac_sleep(dac_sleep), .switch_mode_field(switch_mode_field),
   .sync_ctrl_enable(sync_ctrl_enable), .sync_role_select(sync_role_select),
   .sync_auto_relock(sync_auto_relock), .receiver_ctrl_enable(receiver_ctrl_enable),
   .receiver_auto_relock(receiver_auto_relock), .sync_flag_clear(sync_flag_clear),
   .receiver_flag_clear(receiver_flag_clear), .sync_restart(sync_restart),
   .receiver_restart(receiver_restart), .irq_request(irq_request));

// >>> verification/dicr_regs_tb.sv
// Self-checking testbench for the interrupt and control register block.
`timescale 1ns/1ps
`include "dicr_defs.vh"

module dicr_regs_tb;
   reg clk_sys = 1'b0;
   reg resetn = 1'b0;
   reg spi_sclk = 1'b0;
   reg spi_csn = 1'b1;
   reg spi_sdi = 1'b0;
   reg sync_lock = 1'b0;
   reg phase_ctrl_lock = 1'b0;
   reg receiver_lock = 1'b0;
   reg [3:0] phase_in = 4'h0;
   reg [7:0] rd;
   reg oe_seen = 1'b0;
   wire spi_sdo, spi_sdo_oe, dac_sleep, sync_ctrl_enable, sync_role_select, sync_auto_relock;
   wire receiver_ctrl_enable, receiver_auto_relock, sync_flag_clear, receiver_flag_clear;
   wire sync_restart, receiver_restart, irq_request;
   wire [9:0] full_scale_code;
   wire [1:0] switch_mode_field;
   wire [4:0] ctl = {sync_auto_relock, sync_role_select, sync_ctrl_enable,
      receiver_auto_relock, receiver_ctrl_enable};
   integer n_errors = 0, n_checks = 0, n_cycles = 0;
   integer n_srst = 0, n_rrst = 0, n_sclr = 0, n_rclr = 0;

   always #12.5 clk_sys = ~clk_sys;

   dicr_regs #(.CODE_W(10)) i_dut (
      .clk_sys(clk_sys), .resetn(resetn), .spi_sclk(spi_sclk), .spi_csn(spi_csn),
      .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .sync_lock(sync_lock),
      .phase_ctrl_lock(phase_ctrl_lock), .receiver_lock(receiver_lock),
      .clock_early_phase0_status(phase_in[3]), .clock_late_phase0_status(phase_in[2]),
      .sync_in_phase90_status(phase_in[1]), .sync_in_phase0_status(phase_in[0]),
      .full_scale_code(full_scale_code), .dac_sleep(dac_sleep),
      .switch_mode_field(switch_mode_field), .sync_ctrl_enable(sync_ctrl_enable),
      .sync_role_select(sync_role_select), .sync_auto_relock(sync_auto_relock),
      .receiver_ctrl_enable(receiver_ctrl_enable),
      .receiver_auto_relock(receiver_auto_relock), .sync_flag_clear(sync_flag_clear),
      .receiver_flag_clear(receiver_flag_clear), .sync_restart(sync_restart),
      .receiver_restart(receiver_restart), .irq_request(irq_request));

   // Pulses are counted here so scenarios can judge how many occurred.
   always @(posedge clk_sys) begin
      n_cycles = n_cycles + 1;
      if (sync_restart === 1'b1) n_srst = n_srst + 1;
      if (receiver_restart === 1'b1) n_rrst = n_rrst + 1;
      if (sync_flag_clear === 1'b1) n_sclr = n_sclr + 1;
      if (receiver_flag_clear === 1'b1) n_rclr = n_rclr + 1;
      if (n_cycles == 20000) begin
         n_errors = n_errors + 1;
         complete_run;
      end
   end

   task tick(input integer n);
      begin
         repeat (n) @(posedge clk_sys);
         #1;
      end
   endtask

   task check(input [15:0] seen, input [15:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("Error at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
         end
      end
   endtask

   // Sends one 16-bit frame, most significant bit first, and collects the read byte.
   task frame(input rd_n, input [6:0] addr, input [7:0] wd);
      integer i;
      reg [15:0] w;
      begin
         w = {rd_n, addr, wd};
         spi_csn = 1'b0;
         tick(3);
         for (i = 15; i >= 0; i = i - 1) begin
            spi_sdi = w[i];
            tick(4);
            spi_sclk = 1'b1;
            tick(4);
            if (i < 8) rd[i] = spi_sdo;
            if (i == 0) oe_seen = spi_sdo_oe;
            spi_sclk = 1'b0;
         end
         tick(4);
         spi_csn = 1'b1;
         tick(4);
      end
   endtask

   task wr(input [6:0] addr, input [7:0] wd);
      frame(1'b0, addr, wd);
   endtask

   task rdc(input [6:0] addr, input [7:0] mask, input [7:0] exp);
      begin
         frame(1'b1, addr, 8'h00);
         check({7'h00, oe_seen, rd & mask}, {8'h01, exp});
      end
   endtask

   task t_reset;
      begin
         rdc(`DICR_ADDR_IRQ_ST, 8'hFF, 8'h00);
         rdc(`DICR_ADDR_IRQ_EN, 8'hFF, 8'h00);
         rdc(`DICR_ADDR_FSC_LO, 8'hFF, 8'h00);
         rdc(`DICR_ADDR_FSC_HI, 8'h83, 8'h02);
         rdc(`DICR_ADDR_MODE, 8'h03, 8'h00);
         rdc(`DICR_ADDR_CFG, 8'h73, 8'h42);
         rdc(7'h7F, 8'hFF, 8'h00);
         check({6'h00, full_scale_code}, 16'h0200);
         check({11'h000, ctl}, 16'h0012);
      end
   endtask

   task t_fsc;
      begin
         wr(`DICR_ADDR_FSC_LO, 8'hFF);
         wr(`DICR_ADDR_FSC_HI, 8'h83);
         check({6'h00, full_scale_code}, 16'h03FF);
         check({15'h0000, dac_sleep}, 16'h0001);
         rdc(`DICR_ADDR_FSC_HI, 8'h83, 8'h83);
         wr(`DICR_ADDR_FSC_HI, 8'h01);
         check({5'h00, dac_sleep, full_scale_code}, 16'h01FF);
         wr(`DICR_ADDR_IRQ_ST, 8'hFF);
         rdc(`DICR_ADDR_IRQ_ST, 8'hFF, 8'h00);
      end
   endtask

   task t_mode;
      integer m;
      begin
         for (m = 1; m < 4; m = m + 1) begin
            wr(`DICR_ADDR_MODE, m % 3);
            check({14'h0000, switch_mode_field}, m % 3);
            rdc(`DICR_ADDR_MODE, 8'h03, m % 3);
         end
      end
   endtask

   task t_phase;
      integer p;
      begin
         for (p = 0; p < 16; p = p + 5) begin
            phase_in = p;
            tick(2);
            rdc(`DICR_ADDR_DCLK_PH, 8'h05, {5'h00, phase_in[3], 1'b0, phase_in[2]});
            rdc(`DICR_ADDR_SYNC_PH, 8'h30, {2'h0, phase_in[1:0], 4'h0});
         end
      end
   endtask

   task locks(input v);
      begin
         {sync_lock, phase_ctrl_lock, receiver_lock} = {3{v}};
         tick(6);
      end
   endtask

   task t_irq;
      begin
         wr(`DICR_ADDR_IRQ_EN, 8'h3F);
         locks(1'b1);
         rdc(`DICR_ADDR_IRQ_ST, 8'h3F, 8'h15);
         check({15'h0000, irq_request}, 16'h0001);
         locks(1'b0);
         rdc(`DICR_ADDR_IRQ_ST, 8'h3F, 8'h2A);
         locks(1'b1);
         rdc(`DICR_ADDR_IRQ_ST, 8'h3F, 8'h3F);
         wr(`DICR_ADDR_IRQ_EN, 8'h00);
         rdc(`DICR_ADDR_IRQ_ST, 8'h3F, 8'h00);
         check({15'h0000, irq_request}, 16'h0000);
         locks(1'b0);
         rdc(`DICR_ADDR_IRQ_ST, 8'h3F, 8'h00);
         wr(`DICR_ADDR_IRQ_EN, 8'h3F);
         locks(1'b1);
         rdc(`DICR_ADDR_IRQ_ST, 8'h3F, 8'h15);
      end
   endtask

   task t_cfg;
      begin
         wr(`DICR_ADDR_CFG, 8'h13);
         check({11'h000, ctl}, 16'h0007);
         sync_lock = 1'b0;
         receiver_lock = 1'b0;
         tick(6);
         check(n_srst, 16'h0000);
         check(n_rrst, 16'h0001);
         {sync_lock, receiver_lock} = 2'b11;
         wr(`DICR_ADDR_CFG, 8'h53);
         sync_lock = 1'b0;
         tick(6);
         check(n_srst, 16'h0000);
         {sync_lock, receiver_lock} = 2'b11;
         wr(`DICR_ADDR_CFG, 8'h73);
         check({11'h000, ctl}, 16'h001F);
         sync_lock = 1'b0;
         tick(6);
         check(n_srst, 16'h0001);
         rdc(`DICR_ADDR_IRQ_ST, 8'h3F, 8'h27);
         wr(`DICR_ADDR_CFG, 8'hF7);
         wr(`DICR_ADDR_CFG, 8'h73);
         check({n_sclr[7:0], n_rclr[7:0]}, 16'h0101);
         rdc(`DICR_ADDR_IRQ_ST, 8'h3F, 8'h04);
         wr(`DICR_ADDR_IRQ_EN, 8'h00);
         check({15'h0000, irq_request}, 16'h0000);
      end
   endtask

   task complete_run;
      begin
         $display("Checks %0d, errors %0d", n_checks, n_errors);
         if (n_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask

   initial begin
      repeat (8) @(posedge clk_sys);
      #1 resetn = 1'b1;
      tick(1);
      t_reset;
      t_fsc;
      t_mode;
      t_phase;
      t_irq;
      t_cfg;
      complete_run;
   end
endmodule
